// File: rtl/clock_output_control_regs.sv
/*
  Byte register bank steering the clock outputs, with the watchdog that
  raises the alarm flag and the decode of both output-enable pins.
  Assumes the serial interface engine presents one-cycle byte strobes on
  core_clk_i; the two enable pins arrive asynchronously.
*/
`timescale 1ns/10ps

module clock_output_control_regs
   import clk_regs_pkg::*;
#(
   parameter int unsigned WD_CYCLES_0 = WD_CYC_0,
   parameter int unsigned WD_CYCLES_1 = WD_CYC_1,
   parameter int unsigned WD_CYCLES_2 = WD_CYC_2,
   parameter int unsigned WD_CYCLES_3 = WD_CYC_3
) (
   input  wire logic       core_clk_i,
   input  wire logic       rst_b_i,
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   input  wire logic [7:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   output logic      [7:0] reg_rdata_o,
   output logic            reg_hit_o,
   input  wire logic       oe_pin_one_i,
   input  wire logic       second_enable_pin_i,
   output out_ctrl_s       out_ctrl_o,
   output logic            alarm_o
);

   localparam int unsigned IDX_W = $clog2(NUM_REGS);

   // Refused at elaboration: the period mux assumes ascending nonzero limits
   if (WD_CYCLES_0 == 0 || WD_CYCLES_0 > WD_CYCLES_1 ||
       WD_CYCLES_1 > WD_CYCLES_2 || WD_CYCLES_2 > WD_CYCLES_3) begin
      $error("watchdog periods must be nonzero and ascending");
   end

   function automatic logic in_bank(input logic [7:0] addr);
      return (addr >= OFS_OUTPUT_CONTROL) && (addr <= OFS_POWER_REF);
   endfunction

   function automatic logic [IDX_W-1:0] bank_index(input logic [7:0] addr);
      logic [7:0] diff;
      diff = addr - OFS_OUTPUT_CONTROL;
      return diff[IDX_W-1:0];
   endfunction

   function automatic logic [7:0] reset_value(input logic [IDX_W-1:0] idx);
      logic [7:0] v;
      v = 8'h00;
      unique case (idx)
         3'd0: v = RST_OUTPUT_CONTROL;
         3'd1: v = RST_PIN_FUNCTION;
         3'd2: v = RST_PLL_B_LOOP;
         3'd3: v = RST_WATCHDOG;
         3'd4: v = RST_DIFF_PD_POL;
         3'd5: v = RST_DIFF_ONE_CFG;
         3'd6: v = RST_DIFF_TWO_CFG;
         3'd7: v = RST_POWER_REF;
      endcase
      return v;
   endfunction

   function automatic logic [7:0] write_mask(input logic [IDX_W-1:0] idx);
      logic [7:0] v;
      v = 8'h00;
      unique case (idx)
         3'd0: v = WR_OUTPUT_CONTROL;
         3'd1: v = WR_PIN_FUNCTION;
         3'd2: v = WR_PLL_B_LOOP;
         3'd3: v = WR_WATCHDOG;
         3'd4: v = WR_DIFF_PD_POL;
         3'd5: v = WR_DIFF_CFG;
         3'd6: v = WR_DIFF_CFG;
         3'd7: v = WR_POWER_REF;
      endcase
      return v;
   endfunction

   logic [7:0]       regs_ff [NUM_REGS];
   logic [7:0]       rdata_ff;
   logic             alarm_ff;
   logic [31:0]      wd_count_ff;
   logic [1:0]       oe_one_sync_ff;
   logic [1:0]       oe_two_sync_ff;
   out_ctrl_s        out_ctrl_ff;
   out_ctrl_s        nxt_out_ctrl;
   logic             hit;
   logic [IDX_W-1:0] idx;
   logic             wr_hit;
   logic             oe_one;
   logic             oe_two;
   logic [31:0]      wd_limit;
   logic             wd_expire;
   logic             wd_off_write;

   assign hit       = in_bank(reg_addr_i);
   assign idx       = bank_index(reg_addr_i);
   assign wr_hit    = reg_wr_i && hit;
   assign reg_hit_o = hit;

   // Only the second flop of each synchroniser feeds logic
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         oe_one_sync_ff <= 2'b11;
         oe_two_sync_ff <= 2'b11;
      end else begin
         oe_one_sync_ff <= {oe_one_sync_ff[0], oe_pin_one_i};
         oe_two_sync_ff <= {oe_two_sync_ff[0], second_enable_pin_i};
      end
   end
   assign oe_one = oe_one_sync_ff[1];
   assign oe_two = oe_two_sync_ff[1];

   // Reserved and read-only bits ignore writes and keep defaults
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            regs_ff[i] <= reset_value(IDX_W'(i));
         end
      end else if (wr_hit) begin
         regs_ff[idx] <= (reg_wdata_i & write_mask(idx)) |
                         (reset_value(idx) & ~write_mask(idx));
      end
   end

   // alarm flag is read-only, patched in on read
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         rdata_ff <= 8'h00;
      end else if (reg_rd_i) begin
         if (!hit) begin
            rdata_ff <= 8'h00;
         end else if (reg_addr_i == OFS_WATCHDOG) begin
            rdata_ff <= {regs_ff[idx][7:1], alarm_ff};
         end else begin
            rdata_ff <= regs_ff[idx];
         end
      end
   end
   assign reg_rdata_o = rdata_ff;

   logic [7:0] r_out;
   logic [7:0] r_pin;
   logic [7:0] r_pll;
   logic [7:0] r_wd;
   logic [7:0] r_pol;
   logic [7:0] r_d1;
   logic [7:0] r_d2;
   logic [7:0] r_pwr;
   assign r_out = regs_ff[0];
   assign r_pin = regs_ff[1];
   assign r_pll = regs_ff[2];
   assign r_wd  = regs_ff[3];
   assign r_pol = regs_ff[4];
   assign r_d1  = regs_ff[5];
   assign r_d2  = regs_ff[6];
   assign r_pwr = regs_ff[7];

   always_comb begin
      wd_limit = WD_CYCLES_0;
      unique case (r_wd[B_WATCHDOG_TIMEOUT_LO +: 2])
         2'b00: wd_limit = WD_CYCLES_0;
         2'b01: wd_limit = WD_CYCLES_1;
         2'b10: wd_limit = WD_CYCLES_2;
         2'b11: wd_limit = WD_CYCLES_3;
      endcase
   end

   assign wd_expire    = r_wd[B_WATCHDOG_ENABLE] && (wd_count_ff >= wd_limit - 32'd1);
   assign wd_off_write = wr_hit && (reg_addr_i == OFS_WATCHDOG) &&
                         !reg_wdata_i[B_WATCHDOG_ENABLE];

   // counter runs only while enabled; any bank access restarts it
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         wd_count_ff <= 32'h0000_0000;
      end else if (!r_wd[B_WATCHDOG_ENABLE] || wd_expire ||
                   ((reg_wr_i || reg_rd_i) && hit)) begin
         wd_count_ff <= 32'h0000_0000;
      end else begin
         wd_count_ff <= wd_count_ff + 32'd1;
      end
   end

   // expiry sets the flag; disabling the watchdog clears it, set wins
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         alarm_ff <= 1'b0;
      end else if (wd_expire) begin
         alarm_ff <= 1'b1;
      end else if (wd_off_write) begin
         alarm_ff <= 1'b0;
      end
   end
   assign alarm_o = alarm_ff;

   pin_one_role_e role;
   logic          chip_pd;
   logic          diff_one_type_ok;
   logic          diff_two_type_ok;
   logic          diff_one_cmos;
   logic          diff_two_cmos;

   always_comb begin
      role = pin_one_role_e'(r_pin[B_PIN_ONE_ROLE_LO +: 2]);
      // register bit or, pin in power-down role pulled low
      chip_pd = !r_pwr[B_CHIP_POWER_DOWN_N] ||
                (role == ROLE_POWER_DOWN_N && !oe_one);
      // reserved type codes keep the output off
      diff_one_type_ok = (r_d1[B_DIFF_TYPE_LO +: 2] == DIFF_TYPE_LVCMOS) ||
                         (r_d1[B_DIFF_TYPE_LO +: 2] == DIFF_TYPE_LOW_POWER_HCSL);
      diff_two_type_ok = (r_d2[B_DIFF_TYPE_LO +: 2] == DIFF_TYPE_LVCMOS) ||
                         (r_d2[B_DIFF_TYPE_LO +: 2] == DIFF_TYPE_LOW_POWER_HCSL);
      diff_one_cmos = r_d1[B_DIFF_TYPE_LO +: 2] == DIFF_TYPE_LVCMOS;
      diff_two_cmos = r_d2[B_DIFF_TYPE_LO +: 2] == DIFF_TYPE_LVCMOS;

      nxt_out_ctrl = '0;
      nxt_out_ctrl.chip_power_down = chip_pd;
      // tri-state with bias off only while powered down
      nxt_out_ctrl.diff_hiz = chip_pd && r_pol[B_DIFF_HIZ_ON_PD];
      // gate bit hands each diff output to pin two; enables
      nxt_out_ctrl.diffout_one_on = r_out[B_DIFFOUT_ONE_ENABLE] && !chip_pd &&
                                    diff_one_type_ok &&
                                    (!r_out[B_DIFFOUT_ONE_PIN_GATE] || oe_two);
      nxt_out_ctrl.diffout_two_on = r_out[B_DIFFOUT_TWO_ENABLE] && !chip_pd &&
                                    diff_two_type_ok &&
                                    (!r_out[B_DIFFOUT_TWO_PIN_GATE] || oe_two);
      nxt_out_ctrl.diffout_one_from_div3 = r_d1[B_DIFF_SOURCE];
      nxt_out_ctrl.diffout_two_from_div3 = r_d2[B_DIFF_SOURCE];
      nxt_out_ctrl.diffout_one_hcsl =
         r_d1[B_DIFF_TYPE_LO +: 2] == DIFF_TYPE_LOW_POWER_HCSL;
      nxt_out_ctrl.diffout_two_hcsl =
         r_d2[B_DIFF_TYPE_LO +: 2] == DIFF_TYPE_LOW_POWER_HCSL;
      // complement output exists only in LVCMOS mode
      nxt_out_ctrl.diffout_one_b_on = nxt_out_ctrl.diffout_one_on && diff_one_cmos &&
                                      r_d1[B_DIFF_B_ENABLE];
      nxt_out_ctrl.diffout_two_b_on = nxt_out_ctrl.diffout_two_on && diff_two_cmos &&
                                      r_d2[B_DIFF_B_ENABLE];
      nxt_out_ctrl.diffout_one_b_noninv = r_pol[B_DIFFOUT_ONE_B_POL];
      nxt_out_ctrl.diffout_two_b_noninv = r_pol[B_DIFFOUT_TWO_B_POL];
      // drive strength; diff drive matters in LVCMOS mode only
      nxt_out_ctrl.diffout_one_strong    = diff_one_cmos && r_d1[B_DIFF_CMOS_DRIVE];
      nxt_out_ctrl.diffout_two_strong    = diff_two_cmos && r_d2[B_DIFF_CMOS_DRIVE];
      nxt_out_ctrl.single_out_one_strong = r_out[B_SINGLE_OUT_ONE_DRIVE];
      // single output one enable, pin one as its enable
      nxt_out_ctrl.single_out_one_on = r_pin[B_SINGLE_OUT_ONE_EN] && !chip_pd &&
                                       (role != ROLE_SINGLE_OUT_ONE_OE || oe_one);
      // pin one low requests power saving on single output one
      nxt_out_ctrl.single_out_one_saving = role == ROLE_PROACTIVE_SAVING && !oe_one;
      // default bit 0 keeps the 32 kHz clock free-running
      nxt_out_ctrl.single_out_one_32k       = !r_pwr[B_SINGLE_OUT_ONE_DFLT];
      nxt_out_ctrl.single_out_one_from_div4 = r_pwr[B_SINGLE_OUT_ONE_DFLT] &&
                                              r_pwr[B_SINGLE_OUT_ONE_SRC];
      nxt_out_ctrl.bank_one_level = r_out[B_BANK_ONE_LEVEL_LO +: 2];
      // free-run keeps the reference alive through power down
      nxt_out_ctrl.ref_on = r_pwr[B_REF_ENABLE] &&
                            (!chip_pd || r_pwr[B_REF_FREE_RUN]);
      nxt_out_ctrl.fourth_divider_from_xtal = r_out[B_FOURTH_DIV_SOURCE];
      nxt_out_ctrl.fourth_divider_chan_two_on   = r_pwr[B_FOURTH_DIV_CH_TWO];
      nxt_out_ctrl.fourth_divider_chan_three_on = r_pwr[B_FOURTH_DIV_CH_THREE];
      nxt_out_ctrl.pll_b_third_order = r_pll[B_PLL_B_ORDER_CFG];
      nxt_out_ctrl.pll_b_extra_pole  = r_pll[B_PLL_B_EXTRA_POLE];
      nxt_out_ctrl.pll_b_chan_two_on = r_pll[B_PLL_B_CHAN_TWO];
      nxt_out_ctrl.freq_switch_on = r_wd[B_FREQ_SWITCH_ENABLE];
      // software choice; pin one replaces the low bit in select role
      nxt_out_ctrl.freq_choice = r_pin[B_SOFT_FREQ_CHOICE_LO +: 2];
      if (role == ROLE_FREQ_SELECT_ZERO) begin
         nxt_out_ctrl.freq_choice[0] = oe_one;
      end
   end

   // Registered so the analog controls never see decode glitches
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         out_ctrl_ff <= '0;
      end else begin
         out_ctrl_ff <= nxt_out_ctrl;
      end
   end
   assign out_ctrl_o = out_ctrl_ff;

endmodule

// File: pkg/clk_regs_pkg.sv
/*
  Constants and types for the clock output control register bank.
  Assumes a serial interface engine elsewhere turns bus frames into byte
  read and write strobes on the core clock.
*/
// How it works
// - Gate bits put diff outputs under pin two
// - Enable bits for single and diff outputs
// - Fourth divider source: PLL two or crystal
// - Drive bits choose normal or strong
// - Bank one level field, resets to 1.8 V
// - Pin one role: enable, power-down, saving, select
// - Software frequency choice picks one of four
// - Frequency switch enable bit
// - PLL two order and extra pole bits
// - PLL two channel two enable
// - Watchdog enable bit
// - Watchdog timeout: 250ms, 500ms, 2s, 4s
// - Read-only alarm flag
// - Diff outputs high-Z during power down
// - Complement output polarity per diff output
// - Diff source divider one or three
// - Diff type LVCMOS or low-power HCSL
// - Complement LVCMOS output enable
// - Chip power-down bit, zero powers down
// - Single output one default and source
// - Fourth divider channel two/three enables
package clk_regs_pkg;

   localparam int unsigned CLK_HZ = 25_000_000;

   localparam logic [7:0] OFS_OUTPUT_CONTROL = 8'h1d;
   localparam logic [7:0] OFS_PIN_FUNCTION   = 8'h1e;
   localparam logic [7:0] OFS_PLL_B_LOOP     = 8'h1f;
   localparam logic [7:0] OFS_WATCHDOG       = 8'h20;
   localparam logic [7:0] OFS_DIFF_PD_POL    = 8'h21;
   localparam logic [7:0] OFS_DIFF_ONE_CFG   = 8'h22;
   localparam logic [7:0] OFS_DIFF_TWO_CFG   = 8'h23;
   localparam logic [7:0] OFS_POWER_REF      = 8'h24;
   localparam int unsigned NUM_REGS          = 8;

   localparam logic [7:0] RST_OUTPUT_CONTROL = 8'h33;
   localparam logic [7:0] RST_PIN_FUNCTION   = 8'h90;
   localparam logic [7:0] RST_PLL_B_LOOP     = 8'h04;
   localparam logic [7:0] RST_WATCHDOG       = 8'h80;
   localparam logic [7:0] RST_DIFF_PD_POL    = 8'hb0;
   localparam logic [7:0] RST_DIFF_ONE_CFG   = 8'hb4;
   localparam logic [7:0] RST_DIFF_TWO_CFG   = 8'h34;
   localparam logic [7:0] RST_POWER_REF      = 8'h8c;

   // Writable bits; the rest hold their reset value
   localparam logic [7:0] WR_OUTPUT_CONTROL  = 8'hff;
   localparam logic [7:0] WR_PIN_FUNCTION    = 8'he3;
   localparam logic [7:0] WR_PLL_B_LOOP      = 8'h0e;
   localparam logic [7:0] WR_WATCHDOG        = 8'h1e;
   localparam logic [7:0] WR_DIFF_PD_POL     = 8'h07;
   localparam logic [7:0] WR_DIFF_CFG        = 8'hb3;
   localparam logic [7:0] WR_POWER_REF       = 8'hdf;

   // output_control
   localparam int unsigned B_DIFFOUT_ONE_PIN_GATE = 7;
   localparam int unsigned B_DIFFOUT_TWO_PIN_GATE = 6;
   localparam int unsigned B_DIFFOUT_ONE_ENABLE   = 5;
   localparam int unsigned B_DIFFOUT_TWO_ENABLE   = 4;
   localparam int unsigned B_FOURTH_DIV_SOURCE    = 3;
   localparam int unsigned B_SINGLE_OUT_ONE_DRIVE = 2;
   localparam int unsigned B_BANK_ONE_LEVEL_LO    = 0;
   // pin_function_and_freq_select
   localparam int unsigned B_SINGLE_OUT_ONE_EN    = 7;
   localparam int unsigned B_PIN_ONE_ROLE_LO      = 5;
   localparam int unsigned B_SOFT_FREQ_CHOICE_LO  = 0;
   // pll2_loop_control
   localparam int unsigned B_PLL_B_ORDER_CFG      = 3;
   localparam int unsigned B_PLL_B_CHAN_TWO       = 2;
   localparam int unsigned B_PLL_B_EXTRA_POLE     = 1;
   // watchdog_and_freq_switch_control
   localparam int unsigned B_FREQ_SWITCH_ENABLE   = 4;
   localparam int unsigned B_WATCHDOG_ENABLE      = 3;
   localparam int unsigned B_WATCHDOG_TIMEOUT_LO  = 1;
   localparam int unsigned B_ALARM_FLAG           = 0;
   // diff_power_down_and_polarity
   localparam int unsigned B_DIFF_HIZ_ON_PD       = 2;
   localparam int unsigned B_DIFFOUT_ONE_B_POL    = 1;
   localparam int unsigned B_DIFFOUT_TWO_B_POL    = 0;
   // diff_out_one_config / diff_out_two_config
   localparam int unsigned B_DIFF_SOURCE          = 7;
   localparam int unsigned B_DIFF_TYPE_LO         = 4;
   localparam int unsigned B_DIFF_CMOS_DRIVE      = 1;
   localparam int unsigned B_DIFF_B_ENABLE        = 0;
   // power_and_ref_control
   localparam int unsigned B_CHIP_POWER_DOWN_N    = 7;
   localparam int unsigned B_REF_FREE_RUN         = 6;
   localparam int unsigned B_SINGLE_OUT_ONE_DFLT  = 4;
   localparam int unsigned B_SINGLE_OUT_ONE_SRC   = 3;
   localparam int unsigned B_REF_ENABLE           = 2;
   localparam int unsigned B_FOURTH_DIV_CH_THREE  = 1;
   localparam int unsigned B_FOURTH_DIV_CH_TWO    = 0;

   localparam logic [1:0] DIFF_TYPE_LVCMOS         = 2'b00;
   localparam logic [1:0] DIFF_TYPE_LOW_POWER_HCSL = 2'b11;

   typedef enum logic [1:0] {
      ROLE_SINGLE_OUT_ONE_OE = 2'b00,
      ROLE_POWER_DOWN_N      = 2'b01,
      ROLE_PROACTIVE_SAVING  = 2'b10,
      ROLE_FREQ_SELECT_ZERO  = 2'b11
   } pin_one_role_e;

   // Watchdog periods in milliseconds, codes 00..11
   localparam int unsigned WD_MS_0 = 250;
   localparam int unsigned WD_MS_1 = 500;
   localparam int unsigned WD_MS_2 = 2000;
   localparam int unsigned WD_MS_3 = 4000;
   localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
   localparam int unsigned WD_CYC_0 = WD_MS_0 * CYC_PER_MS;
   localparam int unsigned WD_CYC_1 = WD_MS_1 * CYC_PER_MS;
   localparam int unsigned WD_CYC_2 = WD_MS_2 * CYC_PER_MS;
   localparam int unsigned WD_CYC_3 = WD_MS_3 * CYC_PER_MS;

   typedef struct packed {
      logic       chip_power_down;
      logic       diff_hiz;
      logic       diffout_one_on;
      logic       diffout_two_on;
      logic       diffout_one_from_div3;
      logic       diffout_two_from_div3;
      logic       diffout_one_hcsl;
      logic       diffout_two_hcsl;
      logic       diffout_one_b_on;
      logic       diffout_two_b_on;
      logic       diffout_one_b_noninv;
      logic       diffout_two_b_noninv;
      logic       diffout_one_strong;
      logic       diffout_two_strong;
      logic       single_out_one_on;
      logic       single_out_one_saving;
      logic       single_out_one_32k;
      logic       single_out_one_from_div4;
      logic       single_out_one_strong;
      logic [1:0] bank_one_level;
      logic       ref_on;
      logic       fourth_divider_from_xtal;
      logic       fourth_divider_chan_two_on;
      logic       fourth_divider_chan_three_on;
      logic       pll_b_third_order;
      logic       pll_b_extra_pole;
      logic       pll_b_chan_two_on;
      logic       freq_switch_on;
      logic [1:0] freq_choice;
   } out_ctrl_s;

endpackage

// File: tb/clock_output_control_regs_monitor.sv
/* Port assertions for the clock output register bank.
   Bound to the design top from the bench; one clock, sync low reset. */
`timescale 1ns/10ps
module regs_checker
   import clk_regs_pkg::*;
(
   input wire logic       core_clk_i,
   input wire logic       rst_b_i,
   input wire logic       reg_wr_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic       reg_hit_o,
   input wire out_ctrl_s  out_ctrl_o
);
   default clocking ck @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_b_i);

   sequence wr_to(logic [7:0] a);
      reg_wr_i && reg_addr_i == a;
   endsequence
   sequence reset_release;
      !rst_b_i ##1 rst_b_i;
   endsequence

   reset_level_a:
      assert property (disable iff (1'b0) reset_release |=>
         !rst_b_i || out_ctrl_o.bank_one_level == 2'b11) else $error("bank level after reset");
   diff_enable_a:
      assert property (wr_to(8'h1d) and !reg_wdata_i[5] |-> ##2 !out_ctrl_o.diffout_one_on)
      else $error("diff one still on");
   power_down_a:
      assert property (wr_to(8'h24) and !reg_wdata_i[7] |-> ##2 out_ctrl_o.chip_power_down)
      else $error("no power down");
   source_follow_a:
      assert property (wr_to(8'h22) |->
         ##2 out_ctrl_o.diffout_one_from_div3 == $past(reg_wdata_i[7], 2)) else $error("source");
   soft_choice_a:
      assert property (wr_to(8'h1e) and reg_wdata_i[6:5] != 2'b11 |->
         ##2 out_ctrl_o.freq_choice == $past(reg_wdata_i[1:0], 2)) else $error("freq choice");
   hiz_needs_pd_a:
      assert property (out_ctrl_o.diff_hiz |-> out_ctrl_o.chip_power_down)
      else $error("high-Z outside power down");
   pd_outputs_off_a:
      assert property (out_ctrl_o.chip_power_down |->
         !out_ctrl_o.diffout_one_on && !out_ctrl_o.diffout_two_on) else $error("on in power down");
   b_only_cmos_a:
      assert property (out_ctrl_o.diffout_one_b_on |-> !out_ctrl_o.diffout_one_hcsl)
      else $error("complement on in HCSL");
   single_source_a:
      assert property (out_ctrl_o.single_out_one_from_div4 |-> !out_ctrl_o.single_out_one_32k)
      else $error("two sources");
   hit_decode_a:
      assert property (reg_hit_o == (reg_addr_i >= OFS_OUTPUT_CONTROL &&
         reg_addr_i <= OFS_POWER_REF)) else $error("address decode");
endmodule

// File: tb/serial_host_model.sv
/* Byte host standing in for the serial interface engine.
   Drives 1 ns after the rising edge; one strobe cycle per byte. */
`timescale 1ns/10ps
module serial_host_model (
   input  wire logic       core_clk_i,
   input  wire logic [7:0] reg_rdata_i,
   output logic            reg_wr_o,
   output logic            reg_rd_o,
   output logic      [7:0] reg_addr_o,
   output logic      [7:0] reg_wdata_o
);
   initial begin
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_addr_o = 8'h00;
      reg_wdata_o = 8'h00;
   end
   // Released lines flip so stale values never pass for data
   task automatic drop();
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_addr_o = ~reg_addr_o;
      reg_wdata_o = ~reg_wdata_o;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_i) #1;
      reg_wr_o = 1'b1;
      reg_addr_o = a;
      reg_wdata_o = d;
      @(posedge core_clk_i) #1;
      drop();
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk_i) #1;
      reg_rd_o = 1'b1;
      reg_addr_o = a;
      @(posedge core_clk_i) #1;
      d = reg_rdata_i;
      drop();
   endtask
endmodule

// File: tb/clock_output_control_regs_tb.sv
/* Self-checking bench for the clock output register bank.
   Uses the host model for byte access and shortened watchdog limits. */
`timescale 1ns/10ps
module clock_output_control_regs_tb;
   import clk_regs_pkg::*;
   localparam int WD [4] = '{20, 40, 80, 160};
   localparam logic [7:0] RV [8] = '{8'h33, 8'h90, 8'h04, 8'h80, 8'hb0, 8'hb4, 8'h34, 8'h8c};
   localparam logic [7:0] WM [8] = '{WR_OUTPUT_CONTROL, WR_PIN_FUNCTION, WR_PLL_B_LOOP,
      WR_WATCHDOG, WR_DIFF_PD_POL, WR_DIFF_CFG, WR_DIFF_CFG, WR_POWER_REF};
   logic       core_clk = 1'b0;
   logic       rst_b = 1'b0;
   logic       pin_one = 1'b1;
   logic       pin_two = 1'b1;
   logic       wr;
   logic       rd;
   logic       alarm;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic [7:0] v;
   out_ctrl_s  oc;
   int         miscompares = 0;
   int         n_checks = 0;

   always #20 core_clk = ~core_clk;

   clock_output_control_regs #(.WD_CYCLES_0(WD[0]), .WD_CYCLES_1(WD[1]),
      .WD_CYCLES_2(WD[2]), .WD_CYCLES_3(WD[3])) clock_output_control_regs_i (
      .core_clk_i(core_clk), .rst_b_i(rst_b), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_hit_o(),
      .oe_pin_one_i(pin_one), .second_enable_pin_i(pin_two), .out_ctrl_o(oc),
      .alarm_o(alarm));
   serial_host_model serial_host_model_i (.core_clk_i(core_clk), .reg_rdata_i(rdata),
      .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr), .reg_wdata_o(wdata));

   task automatic put(input logic [7:0] a, input logic [7:0] d);
      serial_host_model_i.wr(a, d);
   endtask
   task automatic get(input logic [7:0] a);
      serial_host_model_i.rd(a, v);
   endtask
   task automatic edges(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      edges(2);
      rst_b = 1'b1;
      for (int i = 0; i < 8; i++) begin
         get(8'h1d + i[7:0]);
         chk(v, RV[i]);
      end
      chk({oc.diffout_one_on, oc.diffout_two_on, oc.single_out_one_on, oc.diffout_one_from_div3,
         oc.diffout_two_from_div3, oc.diffout_one_hcsl, oc.diffout_two_hcsl,
         oc.pll_b_chan_two_on}, 8'hf7);
      chk({oc.bank_one_level, oc.ref_on, oc.chip_power_down, oc.single_out_one_32k,
         oc.freq_switch_on, oc.freq_choice}, 8'he8);
      $display("reset values done");
      for (int i = 0; i < 8; i++) begin
         put(8'h1d + i[7:0], 8'hff);
         get(8'h1d + i[7:0]);
         chk(v, RV[i] & ~WM[i] | WM[i]);
         put(8'h1d + i[7:0], 8'h00);
         get(8'h1d + i[7:0]);
         chk(v, RV[i] & ~WM[i]);
         put(8'h1d + i[7:0], RV[i]);
      end
      put(8'h25, 8'h00);
      get(8'h24);
      chk(v, 8'h8c);
      get(8'h25);
      chk(v, 8'h00);
      $display("access done");
      for (int r = 0; r < 4; r++) begin
         put(OFS_PIN_FUNCTION, 8'h91 | (r[7:0] << 5));
         pin_one = 1'b0;
         edges(4);
         v = {4'h0, oc.single_out_one_on, oc.chip_power_down, oc.single_out_one_saving,
            oc.freq_choice[0]};
         chk({7'h0, v[3-r]}, {7'h0, r == 1 || r == 2});
         pin_one = 1'b1;
         edges(4);
         v = {4'h0, oc.single_out_one_on, oc.chip_power_down, oc.single_out_one_saving,
            oc.freq_choice[0]};
         chk({7'h0, v[3-r]}, {7'h0, r == 0 || r == 3});
      end
      for (int c = 0; c < 4; c++) begin
         put(OFS_PIN_FUNCTION, 8'h90 | c[7:0]);
         put(OFS_WATCHDOG, 8'h90);
         edges(1);
         chk({5'h0, oc.freq_switch_on, oc.freq_choice}, 8'h04 | c[7:0]);
      end
      put(OFS_WATCHDOG, 8'h80);
      $display("pin roles done");
      put(OFS_OUTPUT_CONTROL, 8'hbf);
      pin_two = 1'b0;
      edges(4);
      chk({4'h0, oc.diffout_one_on, oc.diffout_two_on, oc.fourth_divider_from_xtal,
         oc.single_out_one_strong}, 8'h07);
      pin_two = 1'b1;
      edges(4);
      chk({7'h0, oc.diffout_one_on}, 8'h01);
      put(OFS_DIFF_PD_POL, 8'hb4);
      put(OFS_POWER_REF, 8'h0c);
      edges(1);
      chk({5'h0, oc.chip_power_down, oc.diff_hiz, oc.ref_on}, 8'h06);
      put(OFS_POWER_REF, 8'h4c);
      edges(1);
      chk({7'h0, oc.ref_on}, 8'h01);
      put(OFS_POWER_REF, 8'h9f);
      edges(1);
      chk({2'h0, oc.chip_power_down, oc.single_out_one_from_div4, oc.single_out_one_32k,
         oc.fourth_divider_chan_two_on, oc.fourth_divider_chan_three_on, oc.ref_on},
         8'h17);
      put(OFS_DIFF_ONE_CFG, 8'h87);
      put(OFS_DIFF_PD_POL, 8'hb2);
      edges(1);
      chk({2'h0, oc.diffout_one_hcsl, oc.diffout_one_b_on, oc.diffout_one_b_noninv,
         oc.diffout_one_strong, oc.diffout_one_on, oc.diffout_one_from_div3}, 8'h1f);
      put(OFS_DIFF_ONE_CFG, 8'h97);
      edges(1);
      chk({6'h0, oc.diffout_one_on, oc.diffout_one_b_on}, 8'h00);
      put(OFS_DIFF_ONE_CFG, 8'hb4);
      put(OFS_PLL_B_LOOP, 8'h0a);
      put(OFS_DIFF_TWO_CFG, 8'h03);
      put(OFS_DIFF_PD_POL, 8'hb1);
      edges(1);
      chk({1'h0, oc.pll_b_third_order, oc.pll_b_chan_two_on, oc.pll_b_extra_pole,
         oc.diffout_two_on, oc.diffout_two_b_on, oc.diffout_two_b_noninv,
         oc.diffout_two_strong}, 8'h5f);
      put(OFS_DIFF_TWO_CFG, RST_DIFF_TWO_CFG);
      $display("output controls done");
      for (int t = 0; t < 4; t++) begin
         put(OFS_WATCHDOG, 8'h88 | (t[7:0] << 1));
         edges(WD[t] - 1);
         chk({7'h0, alarm}, 8'h00);
         edges(1);
         chk({7'h0, alarm}, 8'h01);
         get(OFS_WATCHDOG);
         chk(v & 8'h01, 8'h01);
         put(OFS_WATCHDOG, 8'h80);
         edges(1);
         chk({7'h0, alarm}, 8'h00);
      end
      put(OFS_WATCHDOG, 8'h88);
      edges(WD[0] + 6);
      rst_b = 1'b0;
      edges(2);
      rst_b = 1'b1;
      chk({7'h0, alarm}, 8'h00);
      get(OFS_WATCHDOG);
      chk(v, 8'h80);
      $display("watchdog done");
      stop_test();
   end

   initial begin
      repeat (6000) @(posedge core_clk);
      miscompares++;
      stop_test();
   end
endmodule

bind clock_output_control_regs regs_checker regs_checker_i (.core_clk_i(core_clk_i),
   .rst_b_i(rst_b_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_hit_o(reg_hit_o), .out_ctrl_o(out_ctrl_o));
